// *** rtl/vcsi_defs.svh ***
`ifndef VCSI_DEFS_SVH
`define VCSI_DEFS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define VCSI_CLK_HZ        20000000
`define VCSI_FLASH_HZ      1
`define VCSI_FLASH_HALF    (`VCSI_CLK_HZ / (2 * `VCSI_FLASH_HZ))
`define VCSI_SYNC_STAGES   2

// ----------------------------------------
// register map
// ----------------------------------------
`define VCSI_ADDR_W        4
`define VCSI_REG_STATUS    4'h0
`define VCSI_REG_MASK      4'h1
`define VCSI_REG_LAMPS     4'h2
`define VCSI_REG_CTRL      4'h3
`define VCSI_REG_INPUTS    4'h4

// ----------------------------------------
// event bits
// ----------------------------------------
`define VCSI_EV_W          6
`define VCSI_EV_NOVIDEO    0
`define VCSI_EV_VIDERR     1
`define VCSI_EV_OVERFLOW   2
`define VCSI_EV_HWFAULT    3
`define VCSI_EV_BADLINE    4
`define VCSI_EV_BYPASS     5

// ----------------------------------------
// control bits
// ----------------------------------------
`define VCSI_CTRL_FORCE_BYP 0
`define VCSI_CTRL_ALT_OVF   1

`endif

// *** rtl/vcsi_pkg.sv ***
package vcsi_pkg;
  typedef enum logic [1:0] {
    VCSI_OFF    = 2'b00,
    VCSI_GREEN  = 2'b01,
    VCSI_RED    = 2'b10,
    VCSI_ORANGE = 2'b11
  } vcsi_color_t;

  typedef enum logic [1:0] {
    VCSI_PWR_GREEN  = 2'b00,
    VCSI_PWR_FLASH  = 2'b01,
    VCSI_PWR_ORANGE = 2'b10,
    VCSI_PWR_RED    = 2'b11
  } vcsi_pwr_t;
endpackage

// *** rtl/vcsi_sync.sv ***
`timescale 1ns/1ns
`include "vcsi_defs.svh"

module vcsi_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_r;

  if (WIDTH < 1) begin : gBadWidth
    $error("vcsi_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      stage1_r <= '0;
      syncOut  <= '0;
    end else begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end
endmodule

// *** rtl/vcsi_flasher.sv ***
`timescale 1ns/1ns
`include "vcsi_defs.svh"

module vcsi_flasher #(
  parameter int HALF_PERIOD = `VCSI_FLASH_HALF
) (
  input  wire logic clock,
  input  wire logic rstn,
  output logic      phase
);
  localparam int CW = (HALF_PERIOD > 1) ? $clog2(HALF_PERIOD) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_PERIOD - 1);
  logic [CW-1:0] count_r;

  if (HALF_PERIOD < 1) begin : gBadHalf
    $error("vcsi_flasher: HALF_PERIOD must be at least 1");
  end

  // ----------------------------------------
  // half-period divider
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      count_r <= '0;
      phase   <= 1'b0;
    end else if (count_r == LAST) begin
      count_r <= '0;
      phase   <= ~phase;
    end else begin
      count_r <= count_r + 1'b1;
    end
  end

  a_flash_period: assert property (@(posedge clock) disable iff (!rstn)
    (count_r == LAST) |=> (phase != $past(phase))) else $error("flash phase did not toggle");
endmodule

// *** rtl/vcsi_status_lamps.sv ***
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "vcsi_defs.svh"

module vcsi_status_lamps #(
  parameter int FLASH_HALF = `VCSI_FLASH_HALF
) (
  input  wire logic                    clock,
  input  wire logic                    rstn,
  // status from card logic (same clock)
  input  wire logic                    bootWait,
  input  wire logic                    videoPresent,
  input  wire logic                    inputValid,
  input  wire logic                    serializerLocked,
  input  wire logic                    hwFault,
  input  wire logic                    inserting,
  input  wire logic                    overflow,
  input  wire logic                    streamError,
  input  wire logic                    rearUnknown,
  input  wire logic                    lineInvalid,
  input  wire logic                    configError,
  // front-edge pushbutton pin
  input  wire logic                    bypassButton,
  output logic                         bypassActive,
  // register port
  input  wire logic [`VCSI_ADDR_W-1:0] regAddr,
  input  wire logic [31:0]             regWdata,
  input  wire logic                    regWrite,
  input  wire logic                    regRead,
  output logic      [31:0]             regRdata,
  output logic                         irq,
  // lamps: bit1 red, bit0 green
  output logic      [1:0]              power_lamp,
  output logic      [1:0]              bypass_lamp,
  output logic      [1:0]              input_video_lamp,
  output logic      [1:0]              output_video_lamp,
  output logic      [1:0]              encode_lamp,
  output logic      [1:0]              video_error_lamp,
  output logic      [1:0]              rear_module_lamp,
  output logic      [1:0]              insertion_line_lamp,
  output logic      [1:0]              no_video_lamp
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic vcsi_pkg::vcsi_color_t pick(input logic bad, input vcsi_pkg::vcsi_color_t badColor);
    pick = bad ? badColor : vcsi_pkg::VCSI_GREEN;
  endfunction

  // ----------------------------------------
  // pushbutton synchroniser and toggle
  // ----------------------------------------
  logic buttonSync;
  logic buttonPrev_r;
  logic bypassed_r;
  logic [`VCSI_EV_W-1:0] ctrl_r;

  vcsi_sync #(.WIDTH(1)) uButtonSync (
    .clock   (clock),
    .rstn    (rstn),
    .asyncIn (bypassButton),
    .syncOut (buttonSync)
  );

  always_ff @(posedge clock) begin
    if (!rstn) begin
      buttonPrev_r <= 1'b0;
      bypassed_r   <= 1'b0;
    end else begin
      buttonPrev_r <= buttonSync;
      if (buttonSync && !buttonPrev_r) begin
        bypassed_r <= ~bypassed_r;
      end
    end
  end

  logic bypassed;
  assign bypassed     = bypassed_r | ctrl_r[`VCSI_CTRL_FORCE_BYP];
  assign bypassActive = bypassed;

  // ----------------------------------------
  // flash timebase
  // ----------------------------------------
  logic flashPhase;

  vcsi_flasher #(.HALF_PERIOD(FLASH_HALF)) uFlasher (
    .clock (clock),
    .rstn  (rstn),
    .phase (flashPhase)
  );

  // ----------------------------------------
  // power lamp state
  // ----------------------------------------
  vcsi_pkg::vcsi_pwr_t pwrState;
  logic notOperational;
  logic warning;

  assign notOperational = !videoPresent || hwFault;
  assign warning        = streamError || configError || rearUnknown || lineInvalid;

  always_comb begin
    if (bootWait) begin
      pwrState = vcsi_pkg::VCSI_PWR_FLASH;
    end else if (notOperational) begin
      pwrState = vcsi_pkg::VCSI_PWR_RED;
    end else if (warning) begin
      pwrState = vcsi_pkg::VCSI_PWR_ORANGE;
    end else begin
      pwrState = vcsi_pkg::VCSI_PWR_GREEN;
    end
  end

  vcsi_pkg::vcsi_color_t pwrColor;

  always_comb begin
    case (pwrState)
      vcsi_pkg::VCSI_PWR_FLASH:  pwrColor = flashPhase ? vcsi_pkg::VCSI_GREEN : vcsi_pkg::VCSI_OFF;
      vcsi_pkg::VCSI_PWR_RED:    pwrColor = vcsi_pkg::VCSI_RED;
      vcsi_pkg::VCSI_PWR_ORANGE: pwrColor = vcsi_pkg::VCSI_ORANGE;
      vcsi_pkg::VCSI_PWR_GREEN:  pwrColor = vcsi_pkg::VCSI_GREEN;
      default:                   pwrColor = vcsi_pkg::VCSI_RED;
    endcase
  end

  // ----------------------------------------
  // encode lamp
  // ----------------------------------------
  vcsi_pkg::vcsi_color_t encColor;

  always_comb begin
    if (!inserting || bypassed) begin
      encColor = vcsi_pkg::VCSI_OFF;
    end else if (overflow) begin
      if (ctrl_r[`VCSI_CTRL_ALT_OVF] && flashPhase) begin
        encColor = vcsi_pkg::VCSI_GREEN;
      end else begin
        encColor = vcsi_pkg::VCSI_ORANGE;
      end
    end else begin
      encColor = vcsi_pkg::VCSI_GREEN;
    end
  end

  // ----------------------------------------
  // lamp output registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      power_lamp          <= 2'h0;
      bypass_lamp         <= 2'h0;
      input_video_lamp    <= 2'h0;
      output_video_lamp   <= 2'h0;
      encode_lamp         <= 2'h0;
      video_error_lamp    <= 2'h0;
      rear_module_lamp    <= 2'h0;
      insertion_line_lamp <= 2'h0;
      no_video_lamp       <= 2'h0;
    end else begin
      power_lamp          <= pwrColor;
      bypass_lamp         <= bypassed ? vcsi_pkg::VCSI_RED : vcsi_pkg::VCSI_OFF;
      input_video_lamp    <= pick(!inputValid, vcsi_pkg::VCSI_RED);
      output_video_lamp   <= hwFault ? vcsi_pkg::VCSI_RED
                           : (serializerLocked ? vcsi_pkg::VCSI_GREEN : vcsi_pkg::VCSI_OFF);
      encode_lamp         <= encColor;
      video_error_lamp    <= pick(streamError, vcsi_pkg::VCSI_ORANGE);
      rear_module_lamp    <= pick(rearUnknown, vcsi_pkg::VCSI_ORANGE);
      insertion_line_lamp <= pick(lineInvalid, vcsi_pkg::VCSI_RED);
      no_video_lamp       <= pick(!videoPresent, vcsi_pkg::VCSI_RED);
    end
  end

  // ----------------------------------------
  // events, status, mask, control
  // ----------------------------------------
  logic [`VCSI_EV_W-1:0] evLevel;
  logic [`VCSI_EV_W-1:0] evPrev_r;
  logic [`VCSI_EV_W-1:0] evRise;
  logic [`VCSI_EV_W-1:0] status_r;
  logic [`VCSI_EV_W-1:0] mask_r;

  always_comb begin
    evLevel = '0;
    evLevel[`VCSI_EV_NOVIDEO]  = !videoPresent;
    evLevel[`VCSI_EV_VIDERR]   = streamError;
    evLevel[`VCSI_EV_OVERFLOW] = overflow && inserting;
    evLevel[`VCSI_EV_HWFAULT]  = hwFault;
    evLevel[`VCSI_EV_BADLINE]  = lineInvalid;
    evLevel[`VCSI_EV_BYPASS]   = bypassed;
  end

  assign evRise = evLevel & ~evPrev_r;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      evPrev_r <= '0;
    end else begin
      evPrev_r <= evLevel;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `VCSI_EV_W; gi++) begin : gStatus
      always_ff @(posedge clock) begin
        if (!rstn) begin
          status_r[gi] <= 1'b0;
        end else if (evRise[gi]) begin
          status_r[gi] <= 1'b1;
        end else if (regWrite && regAddr == `VCSI_REG_STATUS && regWdata[gi]) begin
          status_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rstn) begin
      mask_r <= '0;
      ctrl_r <= '0;
    end else if (regWrite) begin
      if (regAddr == `VCSI_REG_MASK) begin
        mask_r <= regWdata[`VCSI_EV_W-1:0];
      end
      if (regAddr == `VCSI_REG_CTRL) begin
        ctrl_r <= regWdata[`VCSI_EV_W-1:0];
      end
    end
  end

  assign irq = |(status_r & mask_r);

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      regRdata <= 32'h0;
    end else if (regRead) begin
      case (regAddr)
        `VCSI_REG_STATUS: regRdata <= {26'h0, status_r};
        `VCSI_REG_MASK:   regRdata <= {26'h0, mask_r};
        `VCSI_REG_CTRL:   regRdata <= {26'h0, ctrl_r};
        `VCSI_REG_LAMPS:  regRdata <= {14'h0, power_lamp, bypass_lamp, input_video_lamp, output_video_lamp,
                                       encode_lamp, video_error_lamp, rear_module_lamp, insertion_line_lamp,
                                       no_video_lamp};
        `VCSI_REG_INPUTS: regRdata <= {20'h0, bypassed, bootWait, videoPresent, inputValid, serializerLocked,
                                       hwFault, inserting, overflow, streamError, rearUnknown, lineInvalid,
                                       configError};
        default:          regRdata <= 32'h0;
      endcase
    end else begin
      regRdata <= 32'h0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_press;
    buttonSync && !buttonPrev_r;
  endsequence

  a_power_boot: assert property (@(posedge clock) disable iff (!rstn)
    bootWait && flashPhase |=> power_lamp == vcsi_pkg::VCSI_GREEN) else $error("boot flash wrong");
  a_power_red: assert property (@(posedge clock) disable iff (!rstn)
    !bootWait && !videoPresent |=> power_lamp == vcsi_pkg::VCSI_RED) else $error("power not red");
  a_power_orange: assert property (@(posedge clock) disable iff (!rstn)
    !bootWait && videoPresent && !hwFault && streamError |=> power_lamp == vcsi_pkg::VCSI_ORANGE)
    else $error("power not orange");
  a_power_green: assert property (@(posedge clock) disable iff (!rstn)
    !bootWait && !notOperational && !warning |=> power_lamp == vcsi_pkg::VCSI_GREEN)
    else $error("power not green");
  a_bypass_toggle: assert property (@(posedge clock) disable iff (!rstn)
    s_press ##1 1'b1 |-> bypassed_r != $past(bypassed_r)) else $error("press did not toggle");
  a_bypass_lamp: assert property (@(posedge clock) disable iff (!rstn)
    bypassed |=> bypass_lamp == vcsi_pkg::VCSI_RED) else $error("bypass lamp dark");
  a_encode_off: assert property (@(posedge clock) disable iff (!rstn)
    !inserting |=> encode_lamp == vcsi_pkg::VCSI_OFF) else $error("encode lamp lit");
  a_encode_ovf: assert property (@(posedge clock) disable iff (!rstn)
    inserting && !bypassed && overflow && !ctrl_r[`VCSI_CTRL_ALT_OVF] |=> encode_lamp == vcsi_pkg::VCSI_ORANGE)
    else $error("overflow not orange");
  a_novideo_lamp: assert property (@(posedge clock) disable iff (!rstn)
    !videoPresent |=> no_video_lamp == vcsi_pkg::VCSI_RED
      && (input_video_lamp != vcsi_pkg::VCSI_GREEN || $past(inputValid))) else $error("no-video lamp wrong");
  a_line_lamp: assert property (@(posedge clock) disable iff (!rstn)
    lineInvalid |=> insertion_line_lamp == vcsi_pkg::VCSI_RED) else $error("line lamp wrong");
endmodule

// *** dv/vcsi_lamp_model.sv ***
`timescale 1ns/1ns

// ----------------------------------------
// front-edge bicolour lamp
// ----------------------------------------
module vcsi_lamp_model (
  input  wire logic [1:0] lampDrive,
  output logic            redLit,
  output logic            greenLit
);
  // orange shows as both elements lit
  assign redLit   = lampDrive[1];
  assign greenLit = lampDrive[0];
endmodule

// *** dv/video_card_status_indicators_tb.sv ***
`timescale 1ns/1ns
`include "vcsi_defs.svh"

module video_card_status_indicators_tb;
  localparam logic [1:0] LX = 2'h0;
  localparam logic [1:0] LG = 2'h1;
  localparam logic [1:0] LR = 2'h2;
  localparam logic [1:0] LO = 2'h3;
  localparam logic [17:0] NORM = {LG, LX, LG, LG, LX, LG, LG, LG, LG};

  logic        clock = 1'h0;
  logic        rstn = 1'h0;
  logic        bootWait, videoPresent, inputValid, serializerLocked, hwFault, inserting;
  logic        overflow, streamError, rearUnknown, lineInvalid, configError;
  logic        bypassButton = 1'h0;
  logic        bypassActive;
  logic [3:0]  regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic        regWrite = 1'h0;
  logic        regRead = 1'h0;
  logic [31:0] regRdata;
  logic        irq;
  logic [1:0]  power_lamp, bypass_lamp, input_video_lamp, output_video_lamp, encode_lamp;
  logic [1:0]  video_error_lamp, rear_module_lamp, insertion_line_lamp, no_video_lamp;
  logic [17:0] lamps;
  logic        redLit, greenLit;
  logic [31:0] rd;
  int          errorCnt = 0;
  int          checks = 0;

  assign lamps = {power_lamp, bypass_lamp, input_video_lamp, output_video_lamp, encode_lamp,
                  video_error_lamp, rear_module_lamp, insertion_line_lamp, no_video_lamp};

  initial {bootWait, videoPresent, inputValid, serializerLocked, hwFault, inserting,
           overflow, streamError, rearUnknown, lineInvalid, configError} = 11'h380;

  always #25 clock = ~clock;

  vcsi_status_lamps #(.FLASH_HALF(4)) dut_u (
    .clock(clock), .rstn(rstn), .bootWait(bootWait), .videoPresent(videoPresent),
    .inputValid(inputValid), .serializerLocked(serializerLocked), .hwFault(hwFault),
    .inserting(inserting), .overflow(overflow), .streamError(streamError),
    .rearUnknown(rearUnknown), .lineInvalid(lineInvalid), .configError(configError),
    .bypassButton(bypassButton), .bypassActive(bypassActive), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .irq(irq), .power_lamp(power_lamp), .bypass_lamp(bypass_lamp),
    .input_video_lamp(input_video_lamp), .output_video_lamp(output_video_lamp),
    .encode_lamp(encode_lamp), .video_error_lamp(video_error_lamp),
    .rear_module_lamp(rear_module_lamp), .insertion_line_lamp(insertion_line_lamp),
    .no_video_lamp(no_video_lamp)
  );

  vcsi_lamp_model powerLampU (
    .lampDrive(power_lamp),
    .redLit(redLit),
    .greenLit(greenLit)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic printVerdict();
    if (errorCnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errorCnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic regWr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regWrite <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'h0;
  endtask

  task automatic regRd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    regRead <= 1'h1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'h0;
    #1 d = regRdata;
  endtask

  // m leaves out lamps whose colour follows the flash phase
  task automatic step(input logic [10:0] v, input logic [17:0] e, input logic [17:0] m = 18'h3FFFF);
    @(posedge clock);
    {bootWait, videoPresent, inputValid, serializerLocked, hwFault, inserting,
     overflow, streamError, rearUnknown, lineInvalid, configError} <= v;
    repeat (2) @(posedge clock);
    #1 chk({14'h0, lamps & m}, {14'h0, e & m});
  endtask

  // pin press, then bounded wait for the bypass lamp
  task automatic press(input logic [1:0] e);
    int n;
    n = 0;
    @(posedge clock);
    bypassButton <= 1'h1;
    repeat (3) @(posedge clock);
    bypassButton <= 1'h0;
    while (bypass_lamp !== e && n < 10) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk({30'h0, bypass_lamp}, {30'h0, e});
    if (n == 10) printVerdict();
  endtask

  // green on half the samples, six flips in 24 cycles, never red
  task automatic flash();
    int on, tog, red;
    logic last;
    on = 0;
    tog = 0;
    red = 0;
    last = greenLit;
    repeat (24) begin
      @(posedge clock);
      #1;
      on += int'(greenLit === 1'h1);
      tog += int'(greenLit !== last);
      red += int'(redLit !== 1'h0);
      last = greenLit;
    end
    chk(32'(on), 32'd12);
    chk(32'(tog), 32'd6);
    chk(32'(red), 32'd0);
  endtask

  // alternating overflow: four green and four orange in 8 cycles
  task automatic altOvf();
    int grn, org;
    grn = 0;
    org = 0;
    repeat (8) begin
      @(posedge clock);
      #1;
      grn += int'(encode_lamp === LG);
      org += int'(encode_lamp === LO);
    end
    chk(32'(grn), 32'h4);
    chk(32'(org), 32'h4);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    rstn <= 1'h1;
    #1 chk({14'h0, lamps}, 32'h0);
    step(11'h380, NORM);
    regRd(`VCSI_REG_STATUS, rd);
    chk(rd, 32'h0);
    regRd(`VCSI_REG_INPUTS, rd);
    chk(rd, 32'h380);
    step(11'h388, {LO, LX, LG, LG, LX, LO, LG, LG, LG});
    step(11'h384, {LO, LX, LG, LG, LX, LG, LO, LG, LG});
    step(11'h382, {LO, LX, LG, LG, LX, LG, LG, LR, LG});
    step(11'h381, {LO, LX, LG, LG, LX, LG, LG, LG, LG});
    step(11'h3A0, {LG, LX, LG, LG, LG, LG, LG, LG, LG});
    step(11'h3B0, {LG, LX, LG, LG, LO, LG, LG, LG, LG});
    regWr(`VCSI_REG_CTRL, 32'h2);
    regRd(`VCSI_REG_CTRL, rd);
    chk(rd, 32'h2);
    step(11'h3B0, {LG, LX, LG, LG, LO, LG, LG, LG, LG}, 18'h3FCFF);
    altOvf();
    regWr(`VCSI_REG_CTRL, 32'h0);
    step(11'h3C8, {LR, LX, LG, LR, LX, LO, LG, LG, LG});
    step(11'h000, {LR, LX, LR, LX, LX, LG, LG, LG, LR});
    step(11'h400, {LX, LX, LR, LX, LX, LG, LG, LG, LR}, 18'h0FFFF);
    flash();
    step(11'h3A0, {LG, LX, LG, LG, LG, LG, LG, LG, LG});
    press(LR);
    step(11'h3A0, {LG, LR, LG, LG, LX, LG, LG, LG, LG});
    chk({31'h0, bypassActive}, 32'h1);
    regRd(`VCSI_REG_INPUTS, rd);
    chk(rd, 32'hBA0);
    press(LX);
    regWr(`VCSI_REG_CTRL, 32'h1);
    step(11'h380, {LG, LR, LG, LG, LX, LG, LG, LG, LG});
    regWr(`VCSI_REG_CTRL, 32'h0);
    step(11'h380, NORM);
    regRd(`VCSI_REG_STATUS, rd);
    chk(rd, 32'h3F);
    chk({31'h0, irq}, 32'h0);
    regWr(`VCSI_REG_MASK, 32'h1);
    @(posedge clock);
    #1 chk({31'h0, irq}, 32'h1);
    regRd(`VCSI_REG_MASK, rd);
    chk(rd, 32'h1);
    regWr(`VCSI_REG_STATUS, 32'h3F);
    regRd(`VCSI_REG_STATUS, rd);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    regRd(4'hF, rd);
    chk(rd, 32'h0);
    regRd(`VCSI_REG_LAMPS, rd);
    chk(rd, {14'h0, NORM});
    printVerdict();
  end

  initial begin
    repeat (5000) @(posedge clock);
    errorCnt++;
    $display("[ERR] %0t run did not finish", $time);
    printVerdict();
  end
endmodule
